// File: rtl/dao_chan.sv
// one converter channel: output pipeline, format and power states
`timescale 1ns/1ps
`default_nettype none
module dao_chan #(
   parameter int W         = dao_pkg::DAO_W,
   parameter int LAT       = dao_pkg::PIPE_LAT_DEF,
   parameter int SLEEP_CYC = dao_pkg::SLEEP_RECOV_CYC
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   dao_chan_if.chan  ch
);
   import dao_pkg::*;

   logic [W:0]          pipe_reg [LAT];
   logic [W:0]          last;
   dao_pwr_e            st_reg;
   logic [RECOV_CW-1:0] cnt_reg;
   logic                slow_reg;
   logic                fresh_reg;
   logic                step;

   // ======== pipeline ========
   // fixed latency in sample clocks, flag travels with its word
   // head stage split off so no stage ever names an index below zero
   for (genvar g = 0; g < LAT; g++) begin : g_pipe
      if (g == 0) begin : g_head
         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               pipe_reg[g] <= '0;
            end else if (ch.sample_en) begin
               pipe_reg[g] <= {ch.ovr, ch.raw};
            end
         end
      end else begin : g_tail
         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               pipe_reg[g] <= '0;
            end else if (ch.sample_en) begin
               pipe_reg[g] <= pipe_reg[g-1];
            end
         end
      end
   end

   // ======== power states ========
   // nap recovery counts sample clocks, sleep recovery counts system clocks
   assign step = slow_reg | ch.sample_en;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg   <= PWR_RUN;
         cnt_reg  <= '0;
         slow_reg <= 1'b0;
      end else begin
         case (st_reg)
            PWR_RUN: begin
               if (ch.pdn) begin
                  st_reg <= ch.oe_n ? PWR_SLEEP : PWR_NAP;
               end
            end
            PWR_NAP: begin
               if (!ch.pdn) begin
                  st_reg   <= PWR_WAKE;
                  cnt_reg  <= RECOV_CW'(NAP_RECOV_SAMPLES);
                  slow_reg <= 1'b0;
               end else if (ch.oe_n) begin
                  st_reg <= PWR_SLEEP;
               end
            end
            PWR_SLEEP: begin
               // reference is down, so a later nap request stays asleep
               if (!ch.pdn) begin
                  st_reg   <= PWR_WAKE;
                  cnt_reg  <= RECOV_CW'(SLEEP_CYC);
                  slow_reg <= 1'b1;
               end
            end
            PWR_WAKE: begin
               if (ch.pdn) begin
                  st_reg <= (ch.oe_n || slow_reg) ? PWR_SLEEP : PWR_NAP;
               end else if (step) begin
                  cnt_reg <= cnt_reg - 1'b1;
                  if (cnt_reg == 1) begin
                     st_reg <= PWR_RUN;
                  end
               end
            end
            default: begin
               st_reg <= PWR_SLEEP;
            end
         endcase
      end
   end

   // marks the cycle after a pipeline shift
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fresh_reg <= 1'b0;
      end else begin
         fresh_reg <= ch.sample_en;
      end
   end

   // ======== outputs to the top ========
   assign last      = pipe_reg[LAT-1];
   assign ch.word   = ch.twos ? {~last[W-1], last[W-2:0]} : last[W-1:0];
   assign ch.of     = last[W];
   assign ch.mode   = st_reg;
   assign ch.slow   = slow_reg;
   assign ch.valid  = (st_reg == PWR_RUN);
   // drivers off while asleep, napping or disabled
   assign ch.drive  = !ch.oe_n && (st_reg == PWR_RUN || st_reg == PWR_WAKE);
   assign ch.ev_ovf = fresh_reg && ch.valid && last[W];
   assign ch.ev_rdy = (st_reg == PWR_WAKE) && !ch.pdn && step && (cnt_reg == 1);
endmodule
`default_nettype wire

// File: rtl/dao_chan_if.sv
// carrier between the top and one converter channel
`timescale 1ns/1ps
`default_nettype none
interface dao_chan_if #(parameter int W = dao_pkg::DAO_W);
   logic              sample_en;
   logic [W-1:0]      raw;
   logic              ovr;
   logic              pdn;
   logic              oe_n;
   logic              twos;
   logic [W-1:0]      word;
   logic              of;
   logic              drive;
   logic              valid;
   logic              slow;
   dao_pkg::dao_pwr_e mode;
   logic              ev_ovf;
   logic              ev_rdy;
   modport src  (output sample_en, raw, ovr, pdn, oe_n, twos,
                 input  word, of, drive, valid, slow, mode, ev_ovf, ev_rdy);
   modport chan (input  sample_en, raw, ovr, pdn, oe_n, twos,
                 output word, of, drive, valid, slow, mode, ev_ovf, ev_rdy);
endinterface
`default_nettype wire

// File: rtl/dao_pkg.sv
// shared constants and types of the dual converter output control
package dao_pkg;
   // ======== widths and strap levels ========
   localparam int         DAO_W        = 14;
   localparam int         PIPE_LAT_DEF = 5;
   localparam logic [1:0] STRAP_GND    = 2'h0;
   localparam logic [1:0] STRAP_THIRD  = 2'h1;
   localparam logic [1:0] STRAP_TWOTHD = 2'h2;
   localparam logic [1:0] STRAP_VDD    = 2'h3;
   // ======== timing ========
   localparam int MCLK_HZ           = 20_000_000;
   localparam int NAP_RECOV_SAMPLES = 100;
   localparam int SLEEP_RECOV_US    = 1000;
   localparam int SLEEP_RECOV_CYC   = SLEEP_RECOV_US * (MCLK_HZ / 1_000_000);
   localparam int RECOV_CW          = 16;
   // ======== register map ========
   localparam int         ADDR_W     = 4;
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_MASK   = 4'h4;
   localparam logic [3:0] OFS_STATE  = 4'h8;
   localparam int         ST_W       = 4;
   localparam int         ST_OVF_A   = 0;
   localparam int         ST_OVF_B   = 1;
   localparam int         ST_RDY_A   = 2;
   localparam int         ST_RDY_B   = 3;
   localparam logic [3:0] STATUS_RST = 4'h0;
   localparam logic [3:0] MASK_RST   = 4'h0;
   localparam int         SF_TWOS    = 0;
   localparam int         SF_DCS     = 1;
   localparam int         SF_MODE_A  = 2;
   localparam int         SF_MODE_B  = 4;
   localparam int         SF_VALID_A = 6;
   localparam int         SF_VALID_B = 7;
   localparam int         SF_SWAP    = 8;
   // ======== channel power states ========
   typedef enum logic [1:0] {
      PWR_RUN   = 2'b00,
      PWR_NAP   = 2'b01,
      PWR_SLEEP = 2'b10,
      PWR_WAKE  = 2'b11
   } dao_pwr_e;
endpackage

// File: rtl/dao_sync.sv
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module dao_sync #(
   parameter int N = 1
) (
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic [N-1:0] d_i,
   output logic      [N-1:0] q_o
);
   logic [N-1:0] meta_reg;

   // ======== two stages ========
   // first stage feeds only the second one
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_reg <= '0;
         q_o      <= '0;
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// File: rtl/dao_top.sv
// dual converter output control: strap decode, power modes, bus swap, registers
`timescale 1ns/1ps
`default_nettype none
module dao_top #(
   parameter int W         = dao_pkg::DAO_W,
   parameter int LAT       = dao_pkg::PIPE_LAT_DEF,
   parameter int SLEEP_CYC = dao_pkg::SLEEP_RECOV_CYC
) (
   input  wire logic                      mclk_i,
   input  wire logic                      nrst_i,
   input  wire logic                      sample_clock_a_i,
   input  wire logic                      sample_clock_b_i,
   input  wire logic [W-1:0]              conv_code_a_i,
   input  wire logic                      conv_range_a_i,
   input  wire logic [W-1:0]              conv_code_b_i,
   input  wire logic                      conv_range_b_i,
   input  wire logic [1:0]                mode_strap_i,
   input  wire logic                      power_down_request_a_i,
   input  wire logic                      power_down_request_b_i,
   input  wire logic                      output_enable_n_a_i,
   input  wire logic                      output_enable_n_b_i,
   input  wire logic                      bus_swap_select_i,
   input  wire logic [dao_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [31:0]               reg_wdata_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   output logic      [31:0]               reg_rdata_o,
   output logic      [W-1:0]              output_bus_a_o,
   output logic                           output_bus_a_oe_o,
   output logic                           overflow_flag_bus_a_o,
   output logic                           overflow_flag_bus_a_oe_o,
   output logic      [W-1:0]              output_bus_b_o,
   output logic                           output_bus_b_oe_o,
   output logic                           overflow_flag_bus_b_o,
   output logic                           overflow_flag_bus_b_oe_o,
   output logic                           stabilizer_en_o,
   output logic                           irq_o
);
   import dao_pkg::*;

   localparam int NS = 2 * W + 11;

   logic [NS-1:0]   pins;
   logic [NS-1:0]   pins_s;
   logic            swap_s;
   logic            oen_a_s;
   logic            oen_b_s;
   logic            pdn_a_s;
   logic            pdn_b_s;
   logic [1:0]      strap_s;
   logic [W-1:0]    code_a_s;
   logic [W-1:0]    code_b_s;
   logic            range_a_s;
   logic            range_b_s;
   logic            clk_a_s;
   logic            clk_b_s;
   logic            clk_a_prev;
   logic            clk_b_prev;
   logic            twos_reg;
   logic [ST_W-1:0] status_reg;
   logic [ST_W-1:0] mask_reg;
   logic [ST_W-1:0] events;
   logic [ST_W-1:0] clr;
   logic [31:0]     rdata_next;
   logic [RECOV_CW-1:0] wake_n_a;

   dao_chan_if #(.W(W)) ch_a ();
   dao_chan_if #(.W(W)) ch_b ();

   // ======== pin synchronisers ========
   // codes must stay steady a few system clocks around each sample edge,
   // since every bit is synchronised on its own
   assign pins = {sample_clock_b_i, sample_clock_a_i, conv_range_b_i, conv_code_b_i,
                  conv_range_a_i, conv_code_a_i, mode_strap_i, power_down_request_b_i,
                  power_down_request_a_i, output_enable_n_b_i, output_enable_n_a_i,
                  bus_swap_select_i};

   dao_sync #(.N(NS)) u_sync (
      .clk_i  (mclk_i),
      .nrst_i (nrst_i),
      .d_i    (pins),
      .q_o    (pins_s)
   );

   assign {clk_b_s, clk_a_s, range_b_s, code_b_s, range_a_s, code_a_s, strap_s,
           pdn_b_s, pdn_a_s, oen_b_s, oen_a_s, swap_s} = pins_s;

   // sample clocks are seen as levels; rising edges become enables
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         clk_a_prev <= 1'b0;
         clk_b_prev <= 1'b0;
      end else begin
         clk_a_prev <= clk_a_s;
         clk_b_prev <= clk_b_s;
      end
   end

   // ======== strap decode ========
   // one strap serves both channels, so format and stabilizer are shared
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         twos_reg        <= 1'b0;
         stabilizer_en_o <= 1'b0;
      end else begin
         twos_reg        <= (strap_s == STRAP_TWOTHD) || (strap_s == STRAP_VDD);
         stabilizer_en_o <= (strap_s == STRAP_THIRD) || (strap_s == STRAP_TWOTHD);
      end
   end

   // ======== channels ========
   // each channel sees only its own pins and the shared strap format
   assign ch_a.sample_en = clk_a_s & ~clk_a_prev;
   assign ch_a.raw       = code_a_s;
   assign ch_a.ovr       = range_a_s;
   assign ch_a.pdn       = pdn_a_s;
   assign ch_a.oe_n      = oen_a_s;
   assign ch_a.twos      = twos_reg;
   assign ch_b.sample_en = clk_b_s & ~clk_b_prev;
   assign ch_b.raw       = code_b_s;
   assign ch_b.ovr       = range_b_s;
   assign ch_b.pdn       = pdn_b_s;
   assign ch_b.oe_n      = oen_b_s;
   assign ch_b.twos      = twos_reg;

   dao_chan #(.W(W), .LAT(LAT), .SLEEP_CYC(SLEEP_CYC)) u_chan_a (
      .clk_i  (mclk_i),
      .nrst_i (nrst_i),
      .ch     (ch_a.chan)
   );

   dao_chan #(.W(W), .LAT(LAT), .SLEEP_CYC(SLEEP_CYC)) u_chan_b (
      .clk_i  (mclk_i),
      .nrst_i (nrst_i),
      .ch     (ch_b.chan)
   );

   // ======== output buses ========
   // swap is synchronised like any pin, so a shared bus driven by the
   // sample clock only works while that clock is slow next to mclk
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         output_bus_a_o           <= '0;
         output_bus_a_oe_o        <= 1'b0;
         overflow_flag_bus_a_o    <= 1'b0;
         overflow_flag_bus_a_oe_o <= 1'b0;
         output_bus_b_o           <= '0;
         output_bus_b_oe_o        <= 1'b0;
         overflow_flag_bus_b_o    <= 1'b0;
         overflow_flag_bus_b_oe_o <= 1'b0;
      end else if (swap_s) begin
         // straight routing enable follows the source channel
         output_bus_a_o           <= ch_a.word;
         output_bus_a_oe_o        <= ch_a.drive;
         overflow_flag_bus_a_o    <= ch_a.of;
         overflow_flag_bus_a_oe_o <= ch_a.drive;
         output_bus_b_o           <= ch_b.word;
         output_bus_b_oe_o        <= ch_b.drive;
         overflow_flag_bus_b_o    <= ch_b.of;
         overflow_flag_bus_b_oe_o <= ch_b.drive;
      end else begin
         // crossed routing
         output_bus_a_o           <= ch_b.word;
         output_bus_a_oe_o        <= ch_b.drive;
         overflow_flag_bus_a_o    <= ch_b.of;
         overflow_flag_bus_a_oe_o <= ch_b.drive;
         output_bus_b_o           <= ch_a.word;
         output_bus_b_oe_o        <= ch_a.drive;
         overflow_flag_bus_b_o    <= ch_a.of;
         overflow_flag_bus_b_oe_o <= ch_a.drive;
      end
   end

   // ======== status, mask and interrupt ========
   assign events = {ch_b.ev_rdy, ch_a.ev_rdy, ch_b.ev_ovf, ch_a.ev_ovf};
   assign clr    = (reg_wr_i && reg_addr_i == OFS_STATUS) ? reg_wdata_i[ST_W-1:0] : '0;

   // a new event beats a same-cycle clear
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_reg <= STATUS_RST;
      end else begin
         status_reg <= (status_reg & ~clr) | events;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask_reg <= MASK_RST;
      end else if (reg_wr_i && reg_addr_i == OFS_MASK) begin
         mask_reg <= reg_wdata_i[ST_W-1:0];
      end
   end

   // registered, so irq trails the status bit by one cycle
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_reg & mask_reg);
      end
   end

   // ======== register read ========
   always_comb begin
      rdata_next = '0;
      case (reg_addr_i)
         OFS_STATUS: begin
            rdata_next[ST_W-1:0] = status_reg;
         end
         OFS_MASK: begin
            rdata_next[ST_W-1:0] = mask_reg;
         end
         OFS_STATE: begin
            rdata_next[SF_TWOS]              = twos_reg;
            rdata_next[SF_DCS]               = stabilizer_en_o;
            rdata_next[SF_MODE_A+1:SF_MODE_A] = ch_a.mode;
            rdata_next[SF_MODE_B+1:SF_MODE_B] = ch_b.mode;
            rdata_next[SF_VALID_A]           = ch_a.valid;
            rdata_next[SF_VALID_B]           = ch_b.valid;
            rdata_next[SF_SWAP]              = swap_s;
         end
         default: begin
            rdata_next = '0;
         end
      endcase
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rdata_next : '0;
      end
   end

   // ======== checks ========
   // counts sample edges spent recovering, for the nap check
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wake_n_a <= '0;
      end else if (ch_a.mode != PWR_WAKE) begin
         wake_n_a <= '0;
      end else if (ch_a.sample_en) begin
         wake_n_a <= wake_n_a + 1'b1;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   property p_fmt_shared;
      ch_a.twos == ch_b.twos && twos_reg == $past(strap_s[1]);
   endproperty
   a_fmt_shared: assert property (p_fmt_shared) else $error("format not shared");

   property p_dcs;
      stabilizer_en_o == $past(strap_s[0] ^ strap_s[1]);
   endproperty
   a_dcs: assert property (p_dcs) else $error("stabilizer decode wrong");

   property p_ovf_a;
      (swap_s && ch_a.of) |=> overflow_flag_bus_a_o;
   endproperty
   a_ovf_a: assert property (p_ovf_a) else $error("overflow flag lost");

   property p_oe_a;
      (swap_s && oen_a_s) |=> !output_bus_a_oe_o && !overflow_flag_bus_a_oe_o;
   endproperty
   a_oe_a: assert property (p_oe_a) else $error("disabled bus driven");

   sequence s_sleep_req_a;
      (pdn_a_s && oen_a_s) [*3];
   endsequence
   property p_sleep_a;
      s_sleep_req_a |-> ch_a.mode == PWR_SLEEP;
   endproperty
   a_sleep_a: assert property (p_sleep_a) else $error("sleep not entered");

   sequence s_nap_done_a;
      $rose(ch_a.valid) && !ch_a.slow;
   endsequence
   property p_nap_recov_a;
      s_nap_done_a |-> wake_n_a == NAP_RECOV_SAMPLES;
   endproperty
   a_nap_recov_a: assert property (p_nap_recov_a) else $error("nap recovery length");

   property p_down_hiz_a;
      (swap_s && (ch_a.mode == PWR_NAP || ch_a.mode == PWR_SLEEP)) |=> !output_bus_a_oe_o;
   endproperty
   a_down_hiz_a: assert property (p_down_hiz_a) else $error("outputs on while down");

   property p_indep_b;
      (ch_b.mode == PWR_RUN && !pdn_b_s) |=> ch_b.mode == PWR_RUN;
   endproperty
   a_indep_b: assert property (p_indep_b) else $error("channel b disturbed");

   property p_swap;
      swap_s |=> output_bus_a_o == $past(ch_a.word) && output_bus_b_o == $past(ch_b.word);
   endproperty
   a_swap: assert property (p_swap) else $error("straight routing wrong");

   property p_cross;
      !swap_s |=> output_bus_a_o == $past(ch_b.word) && output_bus_b_o == $past(ch_a.word);
   endproperty
   a_cross: assert property (p_cross) else $error("crossed routing wrong");
endmodule
`default_nettype wire

// File: sim/dao_capture.sv
// downstream capture latch watching one output bus of the converter
`timescale 1ns/1ps
`default_nettype none
module dao_capture #(
   parameter int W = 14
) (
   input  wire logic         mclk_i,
   input  wire logic [W-1:0] bus_i,
   input  wire logic         bus_oe_i,
   input  wire logic         flag_i,
   input  wire logic         flag_oe_i,
   output logic      [W-1:0] word_o,
   output logic              flag_o,
   output logic              seen_o
);
   // ==========================================
   // wire levels: a released line has no pull, so it shows the inverse of
   // its last level each clock and the stale word comes back every second clock
   logic [W-1:0] last_reg = '0;
   logic         lastf_reg = 1'b0;
   logic [W-1:0] bus_w;
   logic         flag_w;
   assign bus_w  = bus_oe_i ? bus_i : ~last_reg;
   assign flag_w = flag_oe_i ? flag_i : ~lastf_reg;
   // ==========================================
   // capture every clock; one latch serves a shared bus as well
   always_ff @(posedge mclk_i) begin
      last_reg  <= bus_w;
      lastf_reg <= flag_w;
      word_o    <= bus_w;
      flag_o    <= flag_w;
      seen_o    <= bus_oe_i;
   end
endmodule
`default_nettype wire

// File: sim/dao_top_tb.sv
// self-checking bench of the dual converter output control
`timescale 1ns/1ps
`default_nettype none
module dao_top_tb;
   import dao_pkg::*;
   localparam int W   = DAO_W;
   localparam int LAT = 3;
   localparam int SLP = 50;
   typedef struct {logic [1:0] strap; logic [W-1:0] code; logic rng;
                   logic [W-1:0] bus; logic of; logic stab;} dao_row_s;
   logic mclk = 0, nrst = 0, ca = 0, cb = 0, ra = 0, rb = 0, pa = 0, pb = 0;
   logic oa = 0, ob = 0, sw = 1, wr = 0, rd = 0, oe_a, of_a, ofoe_a, oe_b, of_b, ofoe_b;
   logic stab, irq, cap_f, cap_s;
   logic bus_swap_select = 0;
   logic [1:0]   strap = 0;
   logic [3:0]   addr  = 0;
   logic [31:0]  wdata = 0, rdata, d;
   logic [W-1:0] code_a = 0, code_b = 0, bus_a, bus_b, cap_w, eb;
   int           miscompares = 0, num_checks = 0;
   dao_row_s     rows[4] = '{'{0, 14'h0123, 0, 14'h0123, 0, 0},
                             '{1, 14'h3FFF, 1, 14'h3FFF, 1, 1},
                             '{2, 14'h0000, 0, 14'h2000, 0, 1},
                             '{3, 14'h2ABC, 1, 14'h0ABC, 1, 0}};
   // ==========================================
   // clock and design
   always #25 mclk = ~mclk;
   dao_top #(.W(W), .LAT(LAT), .SLEEP_CYC(SLP)) u_dut (
      .mclk_i(mclk), .nrst_i(nrst), .sample_clock_a_i(ca), .sample_clock_b_i(cb),
      .conv_code_a_i(code_a), .conv_range_a_i(ra), .conv_code_b_i(code_b),
      .conv_range_b_i(rb), .mode_strap_i(strap), .power_down_request_a_i(pa),
      .power_down_request_b_i(pb), .output_enable_n_a_i(oa), .output_enable_n_b_i(ob),
      .bus_swap_select_i(sw), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .output_bus_a_o(bus_a), .output_bus_a_oe_o(oe_a),
      .overflow_flag_bus_a_o(of_a), .overflow_flag_bus_a_oe_o(ofoe_a),
      .output_bus_b_o(bus_b), .output_bus_b_oe_o(oe_b), .overflow_flag_bus_b_o(of_b),
      .overflow_flag_bus_b_oe_o(ofoe_b), .stabilizer_en_o(stab), .irq_o(irq));
   dao_capture #(.W(W)) u_cap (
      .mclk_i(mclk), .bus_i(bus_a), .bus_oe_i(oe_a), .flag_i(of_a), .flag_oe_i(ofoe_a),
      .word_o(cap_w), .flag_o(cap_f), .seen_o(cap_s));
   // ==========================================
   // helpers
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", n, e, g);
      end
   endtask
   // both sample clocks, low 4 then high 8 cycles: code stays steady around the edge;
   // with mux set the swap select follows the clocks as on a shared bus
   task automatic smp(input int n);
      repeat (n) begin
         if (bus_swap_select) sw <= 0;
         ca <= 0; cb <= 0; repeat (4) @(posedge mclk);
         if (bus_swap_select) sw <= 1;
         ca <= 1; cb <= 1; repeat (8) @(posedge mclk);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk); addr <= a; wdata <= v; wr <= 1;
      @(posedge mclk); wr <= 0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic rreg(input logic [3:0] a, output logic [31:0] v);
      @(posedge mclk); addr <= a; rd <= 1;
      @(posedge mclk); rd <= 0;
      @(posedge mclk); v = rdata;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==========================================
   // watchdog: the run needs about 3000 cycles
   initial begin
      #(20000 * 50);
      miscompares++;
      summarize();
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (10) @(posedge mclk);
      chk("rst_oe", 0, {oe_a, oe_b, ofoe_a, ofoe_b, irq});
      nrst <= 1;
      foreach (rows[i]) begin
         strap <= rows[i].strap; code_a <= rows[i].code; code_b <= ~rows[i].code;
         ra <= rows[i].rng; rb <= rows[i].rng;
         smp(LAT + 1);
         eb = rows[i].strap[1] ? (~rows[i].code) ^ 14'h2000 : ~rows[i].code;
         chk("bus_a", rows[i].bus, cap_w);
         chk("of_a", rows[i].of, cap_f);
         chk("bus_b", eb, bus_b);
         chk("of_b", rows[i].of, of_b);
         chk("stab", rows[i].stab, stab);
         rreg(OFS_STATE, d);
         chk("fmt", {rows[i].stab, rows[i].strap[1]}, d[1:0]);
      end
      // masked events raise nothing; clearing one bit leaves the other
      rreg(OFS_STATUS, d); chk("status", 3, d[3:0]);
      chk("irq_off", 0, irq);
      wreg(OFS_MASK, 1); chk("irq_on", 1, irq);
      wreg(OFS_STATUS, 1); chk("irq_clr", 0, irq);
      rreg(OFS_STATUS, d); chk("status_clr", 2, d[3:0]);
      // pipeline depth: distinct words, each due LAT-1 edges later
      strap <= 0; ra <= 0; rb <= 0;
      for (int j = 0; j <= LAT + 1; j++) begin
         code_a <= 14'h0100 + j; code_b <= 14'h0200 + j;
         smp(1);
         if (j >= LAT - 1) chk("lat", 14'h0100 + j - LAT + 1, bus_a);
      end
      // swapped routing
      sw <= 0; repeat (6) @(posedge mclk);
      chk("swap_a", 14'h0200 + 2, bus_a);
      chk("swap_b", 14'h0100 + 2, bus_b);
      wreg(OFS_STATE, 0); rreg(OFS_STATE, d); chk("swap_ro", 0, d[8]);
      // shared bus: swap select tied to both sample clocks
      bus_swap_select = 1;
      smp(1);
      chk("mux_hi", 14'h0100 + 3, cap_w);
      ca <= 0; cb <= 0; sw <= 0; repeat (6) @(posedge mclk);
      chk("mux_lo", 14'h0200 + 3, cap_w);
      bus_swap_select = 0;
      sw <= 1;
      // enable toggled only while idle
      oa <= 1; repeat (6) @(posedge mclk);
      chk("oe_off", 0, {oe_a, ofoe_a, cap_s});
      chk("oe_b", 1, {oe_b & ofoe_b});
      oa <= 0; repeat (6) @(posedge mclk);
      chk("oe_on", 1, {oe_a & ofoe_a});
      // nap then recovery in sample clocks
      pa <= 1; repeat (6) @(posedge mclk);
      chk("nap_oe", 0, {oe_a, ofoe_a});
      chk("nap_b", 1, oe_b);
      rreg(OFS_STATE, d); chk("nap_mode", PWR_NAP, d[3:2]);
      pa <= 0; smp(98);
      rreg(OFS_STATE, d); chk("nap_early", 0, d[6]);
      smp(4);
      rreg(OFS_STATE, d); chk("nap_valid", 1, d[6]);
      rreg(OFS_STATUS, d); chk("nap_rdy", 1, d[2]);
      // sleep then long recovery
      pa <= 1; oa <= 1; repeat (6) @(posedge mclk);
      chk("slp_oe", 0, {oe_a, ofoe_a});
      rreg(OFS_STATE, d); chk("slp_mode", PWR_SLEEP, d[3:2]);
      pa <= 0; oa <= 0; smp(2);
      rreg(OFS_STATE, d); chk("slp_early", 0, d[6]);
      smp(110);
      rreg(OFS_STATE, d); chk("slp_valid", 1, d[6]);
      rreg(4'hC, d); chk("unmapped", 0, d);
      summarize();
   end
endmodule
`default_nettype wire
